// file: core/risc_pipeline_core.sv
// five-stage integer pipeline with delay slots, muldiv unit and exception entry
// Functional notes
// - the instruction after a jump or branch completes before the target runs
// - the delay-slot instruction runs on both taken and not-taken paths
// - branch target and outcome resolve early so fetch redirects after one cycle
// - load data is not forwarded to the next instruction, which does not stall
// - readers of multi-cycle results stall until the result is ready
// - multiply/divide runs on its own and writes only its own result registers
// - a multiply unit start while busy is left to software; a new start simply restarts
// - thirty-two general registers, zero and thirty-one handled specially
// - user-space translation miss goes to its own entry point
// - register zero reads zero and writes to it are dropped
// - jump-and-link writes register 31, jump-and-link-register writes rd, both with jump address plus eight
// - high and low results hold the 64-bit product or remainder and quotient
// - traps save restart address, record cause, mask interrupts, jump to entry
`timescale 1ns/1ps
module risc_pipeline_core #(
  parameter int MULT_CYCLES = risc_pipeline_pkg::MULT_LATENCY,
  parameter int DIV_CYCLES  = risc_pipeline_pkg::DIV_LATENCY
) (
  input  wire logic                          core_clk_in,
  input  wire logic                          rst_in,
  output logic [31:0]                        imem_addr_out,
  input  wire logic [31:0]                   imem_data_in,
  output risc_pipeline_pkg::dmem_req_t       dmem_req_out,
  input  wire logic [31:0]                   dmem_rdata_in,
  input  wire logic                          dmem_tlb_miss_in,
  input  wire logic                          irq_in
);
  import risc_pipeline_pkg::*;

  localparam int MDW = $clog2((MULT_CYCLES > DIV_CYCLES ? MULT_CYCLES : DIV_CYCLES) + 1);

  if (MULT_CYCLES < 1 || DIV_CYCLES < 1) begin : g_bad_latency
    $error("muldiv latencies must be at least one cycle");
  end

  logic [31:0]   pc_f;
  logic          f_valid;
  logic [31:0]   d_instr;
  logic [31:0]   d_pc;
  logic          d_valid;
  logic          d_in_slot;
  exec_stage_t   x;
  mem_stage_t    m;
  wb_stage_t     w;
  logic [31:0]   regs [NUM_REGS];
  logic [31:0]   muldiv_high_result;
  logic [31:0]   muldiv_low_result;
  logic [MDW-1:0] md_count;
  logic          md_is_div;
  logic [31:0]   md_a;
  logic [31:0]   md_b;
  logic [31:0]   exception_return_pc;
  logic [3:0]    cause;
  logic          int_enable;
  logic          irq_meta;
  logic          irq_sync;
  logic [31:0]   x_result;
  exec_stage_t   next_x;
  logic          is_jump;
  logic [31:0]   jump_target;
  logic          mul_start;
  logic          div_start;
  logic          is_syscall;
  logic          is_rfe;
  logic          reads_hilo;
  logic          md_busy;
  logic          hilo_stall;
  logic          mem_fault;
  logic          dec_trap;
  logic          advance_d;
  logic [31:0]   trap_vector;
  logic [63:0]   md_product;
  logic [31:0]   md_quot;
  logic [31:0]   md_rem;

  // operand read with bypass; a load still in execute is skipped on purpose
  function automatic logic [31:0] operand(input logic [4:0] r);
    if (r == REG_ZERO) begin
      return '0;
    end else if (x.valid && x.wr && !x.load && x.dest == r) begin
      return x_result;
    end else if (m.valid && m.wr && m.dest == r) begin
      return m.load ? dmem_rdata_in : m.req.addr;
    end else if (w.wr && w.dest == r) begin
      return w.value;
    end else begin
      return regs[r];
    end
  endfunction

  // decode
  always_comb begin
    logic [5:0]  op;
    logic [5:0]  funct;
    logic [4:0]  rs;
    logic [4:0]  rt;
    logic [4:0]  rd;
    logic [31:0] src_a;
    logic [31:0] src_b;
    logic [31:0] simm;
    logic [31:0] zimm;
    op    = d_instr[31:26];
    funct = d_instr[5:0];
    rs    = d_instr[25:21];
    rt    = d_instr[20:16];
    rd    = d_instr[15:11];
    src_a = operand(rs);
    src_b = operand(rt);
    simm  = {{16{d_instr[15]}}, d_instr[15:0]};
    zimm  = {16'h0000, d_instr[15:0]};
    next_x            = '0;
    next_x.alu        = ALU_ADD;
    next_x.pc         = d_pc;
    next_x.in_slot    = d_in_slot;
    next_x.a          = src_a;
    next_x.b          = src_b;
    next_x.store_data = src_b;
    is_jump     = 1'b0;
    jump_target = d_pc + PC_STEP + {simm[29:0], 2'b00};
    mul_start   = 1'b0;
    div_start   = 1'b0;
    is_syscall  = 1'b0;
    is_rfe      = 1'b0;
    reads_hilo  = 1'b0;
    case (op)
      OP_SPECIAL: begin
        next_x.dest = rd;
        next_x.wr   = 1'b1;
        case (funct)
          F_ADD: next_x.alu = ALU_ADD;
          F_SUB: next_x.alu = ALU_SUB;
          F_AND: next_x.alu = ALU_AND;
          F_OR:  next_x.alu = ALU_OR;
          F_XOR: next_x.alu = ALU_XOR;
          F_SLT: next_x.alu = ALU_SLT;
          F_SLL: begin
            next_x.alu = ALU_SLL;
            next_x.a   = src_b;
            next_x.b   = {27'h0000000, d_instr[10:6]};
          end
          F_JR, F_JALR: begin
            is_jump     = 1'b1;
            jump_target = src_a;
            next_x.wr   = (funct == F_JALR);
            next_x.alu  = ALU_PASSB;
            next_x.b    = d_pc + LINK_STEP;
          end
          F_MFHI, F_MFLO: begin
            reads_hilo = 1'b1;
            next_x.alu = ALU_PASSB;
            next_x.b   = (funct == F_MFHI) ? muldiv_high_result : muldiv_low_result;
          end
          F_MULT: begin
            mul_start = 1'b1;
            next_x.wr = 1'b0;
          end
          F_DIV: begin
            div_start = 1'b1;
            next_x.wr = 1'b0;
          end
          F_SYSCALL: begin
            is_syscall = 1'b1;
            next_x.wr  = 1'b0;
          end
          default: next_x.wr = 1'b0;
        endcase
      end
      OP_J, OP_JAL: begin
        is_jump     = 1'b1;
        jump_target = {d_pc[31:28], d_instr[25:0], 2'b00};
        next_x.wr   = (op == OP_JAL);
        next_x.dest = REG_LINK;
        next_x.alu  = ALU_PASSB;
        next_x.b    = d_pc + LINK_STEP;
      end
      OP_BEQ: is_jump = (src_a == src_b);
      OP_BNE: is_jump = (src_a != src_b);
      OP_ADDI, OP_SLTI, OP_ANDI, OP_ORI, OP_LUI, OP_LW: begin
        next_x.dest = rt;
        next_x.wr   = 1'b1;
        next_x.load = (op == OP_LW);
        next_x.b    = (op == OP_ANDI || op == OP_ORI) ? zimm : simm;
        case (op)
          OP_SLTI: next_x.alu = ALU_SLT;
          OP_ANDI: next_x.alu = ALU_AND;
          OP_ORI:  next_x.alu = ALU_OR;
          OP_LUI: begin
            next_x.alu = ALU_PASSB;
            next_x.b   = {d_instr[15:0], 16'h0000};
          end
          default: next_x.alu = ALU_ADD;
        endcase
      end
      OP_SW: begin
        next_x.store = 1'b1;
        next_x.b     = simm;
      end
      OP_SYS: begin
        next_x.dest = rt;
        next_x.wr   = (rs != SYS_RFE);
        next_x.alu  = ALU_PASSB;
        next_x.b    = (rs == SYS_READ_CAUSE) ? {28'h0000000, cause} : exception_return_pc;
        is_rfe      = (rs == SYS_RFE);
      end
      default: ;
    endcase
  end

  // execute
  always_comb begin
    case (x.alu)
      ALU_ADD:   x_result = x.a + x.b;
      ALU_SUB:   x_result = x.a - x.b;
      ALU_AND:   x_result = x.a & x.b;
      ALU_OR:    x_result = x.a | x.b;
      ALU_XOR:   x_result = x.a ^ x.b;
      ALU_SLT:   x_result = {31'h00000000, $signed(x.a) < $signed(x.b)};
      ALU_SLL:   x_result = x.a << x.b[4:0];
      ALU_PASSB: x_result = x.b;
      default:   x_result = '0;
    endcase
  end

  // hazard and exception control
  assign md_busy     = (md_count != '0);
  assign hilo_stall  = d_valid && reads_hilo && md_busy;
  assign mem_fault   = m.valid && (m.req.rd_en || m.req.wr_en) && dmem_tlb_miss_in;
  assign dec_trap    = d_valid && !hilo_stall && (is_syscall || (irq_sync && int_enable));
  assign advance_d   = d_valid && !hilo_stall && !mem_fault && !dec_trap;
  assign trap_vector = (mem_fault && !m.req.addr[USER_SPACE_BIT]) ? VEC_USER_TLB
                                                                  : VEC_GENERAL;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_meta <= 1'b0;
      irq_sync <= 1'b0;
    end else begin
      irq_meta <= irq_in;
      irq_sync <= irq_meta;
    end
  end

  // fetch and decode registers
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pc_f      <= RESET_PC;
      f_valid   <= 1'b0;
      d_instr   <= '0;
      d_pc      <= '0;
      d_valid   <= 1'b0;
      d_in_slot <= 1'b0;
    end else if (mem_fault || dec_trap) begin
      pc_f      <= trap_vector;
      f_valid   <= 1'b1;
      d_valid   <= 1'b0;
    end else if (!hilo_stall) begin
      // the slot already being fetched is kept whatever the outcome; the reset
      // address is held one more edge since its first word is not yet valid
      pc_f      <= !f_valid ? pc_f
                 : (advance_d && is_jump) ? jump_target : pc_f + PC_STEP;
      f_valid   <= 1'b1;
      d_instr   <= imem_data_in;
      d_pc      <= pc_f;
      d_valid   <= f_valid;
      // the word captured now is the slot of the branch leaving decode
      d_in_slot <= advance_d && (is_jump || d_instr[31:26] == OP_BEQ
                                 || d_instr[31:26] == OP_BNE);
    end
  end

  assign imem_addr_out = pc_f;

  // execute, memory and write-back registers
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      x <= '0;
      m <= '0;
      w <= '0;
    end else begin
      x       <= next_x;
      x.valid <= advance_d;
      m.valid       <= x.valid && !mem_fault;
      m.pc          <= x.pc;
      m.in_slot     <= x.in_slot;
      m.dest        <= x.dest;
      m.wr          <= x.wr;
      m.load        <= x.load;
      m.req.addr    <= x_result;
      m.req.wdata   <= x.store_data;
      m.req.rd_en   <= x.valid && x.load && !mem_fault;
      m.req.wr_en   <= x.valid && x.store && !mem_fault;
      w.wr    <= m.valid && m.wr && !mem_fault;
      w.dest  <= m.dest;
      w.value <= m.load ? dmem_rdata_in : m.req.addr;
    end
  end

  assign dmem_req_out = m.req;

  // register file; entry zero is never written
  always_ff @(posedge core_clk_in) begin
    if (w.wr && w.dest != REG_ZERO) begin
      regs[w.dest] <= w.value;
    end
  end

  // exception state
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      exception_return_pc <= '0;
      cause               <= CAUSE_INT;
      int_enable          <= 1'b0;
    end else if (mem_fault) begin
      exception_return_pc <= m.in_slot ? m.pc - PC_STEP : m.pc;
      cause      <= m.req.addr[USER_SPACE_BIT] ? CAUSE_TLB : CAUSE_USER_TLB;
      int_enable <= 1'b0;
    end else if (dec_trap) begin
      exception_return_pc <= d_in_slot ? d_pc - PC_STEP : d_pc;
      cause      <= is_syscall ? CAUSE_SYSCALL : CAUSE_INT;
      int_enable <= 1'b0;
    end else if (advance_d && is_rfe) begin
      int_enable <= 1'b1;
    end
  end

  // multiply/divide unit; a start while busy restarts it, no interlock
  always_comb begin
    md_product = $signed(md_a) * $signed(md_b);
    md_quot    = (md_b == '0) ? '1 : 32'($signed(md_a) / $signed(md_b));
    md_rem     = (md_b == '0) ? md_a : 32'($signed(md_a) % $signed(md_b));
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      md_count           <= '0;
      md_is_div          <= 1'b0;
      md_a               <= '0;
      md_b               <= '0;
      muldiv_high_result <= '0;
      muldiv_low_result  <= '0;
    end else if (advance_d && (mul_start || div_start)) begin
      md_count  <= div_start ? MDW'(DIV_CYCLES) : MDW'(MULT_CYCLES);
      md_is_div <= div_start;
      md_a      <= next_x.a;
      md_b      <= next_x.b;
    end else if (md_count != '0) begin
      md_count <= md_count - 1'b1;
      if (md_count == MDW'(1)) begin
        muldiv_high_result <= md_is_div ? md_rem : md_product[63:32];
        muldiv_low_result  <= md_is_div ? md_quot : md_product[31:0];
      end
    end
  end

endmodule

// file: core/risc_pipeline_pkg.sv
// shared constants, encodings and stage carriers for the five-stage integer core
package risc_pipeline_pkg;

  localparam int          XLEN          = 32;
  localparam int          NUM_REGS      = 32;
  localparam logic [4:0]  REG_ZERO      = 5'h00;
  localparam logic [4:0]  REG_LINK      = 5'h1f;
  localparam logic [31:0] PC_STEP       = 32'h0000_0004;
  localparam logic [31:0] LINK_STEP     = 32'h0000_0008;

  // entry points
  localparam logic [31:0] RESET_PC      = 32'h0000_0100;
  localparam logic [31:0] VEC_USER_TLB  = 32'h0000_0000;
  localparam logic [31:0] VEC_GENERAL   = 32'h0000_0080;
  localparam int          USER_SPACE_BIT = 31;

  // multiply/divide latency defaults
  localparam int          MULT_LATENCY  = 12;
  localparam int          DIV_LATENCY   = 35;

  // primary opcodes, bits 31:26
  localparam logic [5:0]  OP_SPECIAL    = 6'h00;
  localparam logic [5:0]  OP_J          = 6'h02;
  localparam logic [5:0]  OP_JAL        = 6'h03;
  localparam logic [5:0]  OP_BEQ        = 6'h04;
  localparam logic [5:0]  OP_BNE        = 6'h05;
  localparam logic [5:0]  OP_ADDI       = 6'h08;
  localparam logic [5:0]  OP_SLTI       = 6'h0a;
  localparam logic [5:0]  OP_ANDI       = 6'h0c;
  localparam logic [5:0]  OP_ORI        = 6'h0d;
  localparam logic [5:0]  OP_LUI        = 6'h0f;
  localparam logic [5:0]  OP_SYS        = 6'h10;
  localparam logic [5:0]  OP_LW         = 6'h23;
  localparam logic [5:0]  OP_SW         = 6'h2b;

  // function codes of OP_SPECIAL, bits 5:0
  localparam logic [5:0]  F_SLL         = 6'h00;
  localparam logic [5:0]  F_JR          = 6'h08;
  localparam logic [5:0]  F_JALR        = 6'h09;
  localparam logic [5:0]  F_SYSCALL     = 6'h0c;
  localparam logic [5:0]  F_MFHI        = 6'h10;
  localparam logic [5:0]  F_MFLO        = 6'h12;
  localparam logic [5:0]  F_MULT        = 6'h18;
  localparam logic [5:0]  F_DIV         = 6'h1a;
  localparam logic [5:0]  F_ADD         = 6'h20;
  localparam logic [5:0]  F_SUB         = 6'h22;
  localparam logic [5:0]  F_AND         = 6'h24;
  localparam logic [5:0]  F_OR          = 6'h25;
  localparam logic [5:0]  F_XOR         = 6'h26;
  localparam logic [5:0]  F_SLT         = 6'h2a;

  // OP_SYS sub-operations in the rs field
  localparam logic [4:0]  SYS_READ_EPC  = 5'h00;
  localparam logic [4:0]  SYS_READ_CAUSE = 5'h01;
  localparam logic [4:0]  SYS_RFE       = 5'h10;

  // exception cause codes
  localparam logic [3:0]  CAUSE_INT     = 4'h0;
  localparam logic [3:0]  CAUSE_TLB     = 4'h2;
  localparam logic [3:0]  CAUSE_USER_TLB = 4'h3;
  localparam logic [3:0]  CAUSE_SYSCALL = 4'h8;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_SLT, ALU_SLL, ALU_PASSB
  } alu_op_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        rd_en;
    logic        wr_en;
  } dmem_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] pc;
    logic        in_slot;
    logic [4:0]  dest;
    logic        wr;
    logic        load;
    logic        store;
    alu_op_t     alu;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] store_data;
  } exec_stage_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] pc;
    logic        in_slot;
    logic [4:0]  dest;
    logic        wr;
    logic        load;
    dmem_req_t   req;
  } mem_stage_t;

  typedef struct packed {
    logic        wr;
    logic [4:0]  dest;
    logic [31:0] value;
  } wb_stage_t;

endpackage

// file: tb/risc_pipeline_checker.sv
// port checker for fetch redirection, data access and trap entry of the core
`timescale 1ns/1ps
module risc_pipeline_checker (
  input wire logic                         core_clk_in,
  input wire logic                         rst_in,
  input wire logic [31:0]                  imem_addr_out,
  input wire logic [31:0]                  imem_data_in,
  input wire risc_pipeline_pkg::dmem_req_t dmem_req_out,
  input wire logic [31:0]                  dmem_rdata_in,
  input wire logic                         dmem_tlb_miss_in,
  input wire logic                         irq_in
);
  import risc_pipeline_pkg::*;
  logic [31:0] p1_addr;
  logic [31:0] p1_instr;
  logic [31:0] p2_instr;
  logic [31:0] miss_vec;
  logic        acc;
  logic        any_vec;
  logic        is_jump;
  logic        is_beq;
  logic        is_bne;
  logic        same_regs;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  assign acc = dmem_req_out.rd_en | dmem_req_out.wr_en;
  assign any_vec = imem_addr_out == VEC_USER_TLB || imem_addr_out == VEC_GENERAL;
  assign is_jump = imem_data_in[31:26] inside {OP_J, OP_JAL};
  // a self-compare is the only branch whose outcome the word alone decides
  assign same_regs = imem_data_in[25:21] == imem_data_in[20:16];
  assign is_beq = imem_data_in[31:26] == OP_BEQ && same_regs;
  assign is_bne = imem_data_in[31:26] == OP_BNE && same_regs;
  always_ff @(posedge core_clk_in) begin
    p1_addr <= imem_addr_out;
    p1_instr <= imem_data_in;
    p2_instr <= p1_instr;
  end
  always_ff @(posedge core_clk_in) begin
    if (acc && dmem_tlb_miss_in) begin
      miss_vec <= dmem_req_out.addr[31] ? VEC_GENERAL : VEC_USER_TLB;
    end
  end
  a_reset_fetch_hold: assert property ($fell(rst_in) |->
    imem_addr_out == RESET_PC ##1 imem_addr_out == RESET_PC) else $error("reset pc not held");
  a_slot_fetched: assert property ((is_jump || is_beq || is_bne) |=> any_vec ||
    imem_addr_out == p1_addr || imem_addr_out == p1_addr + PC_STEP) else $error("slot skipped");
  a_jump_target: assert property (is_jump ##1 imem_addr_out == p1_addr + PC_STEP |=>
    any_vec || imem_addr_out == {p1_addr[31:28], p2_instr[25:0], 2'b00})
    else $error("jump target wrong");
  a_taken_branch: assert property (is_beq ##1 imem_addr_out == p1_addr + PC_STEP |=>
    any_vec || imem_addr_out == p1_addr + {{14{p2_instr[15]}}, p2_instr[15:0], 2'b00})
    else $error("branch target wrong");
  a_untaken_branch: assert property (is_bne ##1 imem_addr_out == p1_addr + PC_STEP |=>
    any_vec || imem_addr_out == p1_addr + PC_STEP) else $error("untaken branch redirected");
  a_one_access: assert property (!(dmem_req_out.rd_en && dmem_req_out.wr_en))
    else $error("read and write together");
  a_miss_vector: assert property (acc && dmem_tlb_miss_in |->
    ##[1:2] imem_addr_out == miss_vec) else $error("miss entry point wrong");
  a_trap_quiet: assert property (acc && dmem_tlb_miss_in |=> !acc ##1 !acc)
    else $error("access after trap");
endmodule

// file: tb/risc_memory_model.sv
// behavioural instruction and data memory answering the core in the same cycle
`timescale 1ns/1ps
module risc_memory_model (
  input  wire logic                         core_clk_in,
  input  wire logic [31:0]                  imem_addr_in,
  output logic [31:0]                       imem_data_out,
  input  wire risc_pipeline_pkg::dmem_req_t dmem_req_in,
  output logic [31:0]                       dmem_rdata_out,
  output logic                              dmem_tlb_miss_out
);
  import risc_pipeline_pkg::*;
  logic [31:0] imem [256];
  logic [31:0] dmem [256];
  logic [31:0] noise = 32'h0f0f_1234;
  logic        acc;
  assign acc = dmem_req_in.rd_en | dmem_req_in.wr_en;
  assign imem_data_out = imem[imem_addr_in[9:2]];
  // bit 30 marks untranslated pages; bit 31 then picks the entry point
  assign dmem_tlb_miss_out = acc & dmem_req_in.addr[30];
  // an idle read bus shows a changing pattern, never a stale word
  assign dmem_rdata_out = dmem_req_in.rd_en ? dmem[dmem_req_in.addr[9:2]] : noise;
  always @(posedge core_clk_in) begin
    noise <= {noise[30:0], ~noise[31]};
    if (dmem_req_in.wr_en && !dmem_tlb_miss_out) begin
      dmem[dmem_req_in.addr[9:2]] <= dmem_req_in.wdata;
    end
  end
endmodule

// file: tb/testbench.sv
// self-checking bench for the core: delay slots, loads, muldiv and trap entry
`timescale 1ns/1ps
bind risc_pipeline_core risc_pipeline_checker risc_pipeline_checker_i (
  .core_clk_in(core_clk_in),
  .rst_in(rst_in),
  .imem_addr_out(imem_addr_out),
  .imem_data_in(imem_data_in),
  .dmem_req_out(dmem_req_out),
  .dmem_rdata_in(dmem_rdata_in),
  .dmem_tlb_miss_in(dmem_tlb_miss_in),
  .irq_in(irq_in)
);
module testbench;
  import risc_pipeline_pkg::*;
  logic        core_clk_in;
  logic        rst_in;
  logic        irq_in;
  logic [31:0] imem_addr_out;
  logic [31:0] imem_data_in;
  dmem_req_t   dmem_req_out;
  logic [31:0] dmem_rdata_in;
  logic        dmem_tlb_miss_in;
  logic [31:0] wp;
  int          fail_count;
  int          n_checks;
  risc_pipeline_core #(.MULT_CYCLES(3), .DIV_CYCLES(2)) risc_pipeline_core_i (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .imem_addr_out(imem_addr_out),
    .imem_data_in(imem_data_in),
    .dmem_req_out(dmem_req_out),
    .dmem_rdata_in(dmem_rdata_in),
    .dmem_tlb_miss_in(dmem_tlb_miss_in),
    .irq_in(irq_in)
  );
  risc_memory_model risc_memory_model_i (
    .core_clk_in(core_clk_in),
    .imem_addr_in(imem_addr_out),
    .imem_data_out(imem_data_in),
    .dmem_req_in(dmem_req_out),
    .dmem_rdata_out(dmem_rdata_in),
    .dmem_tlb_miss_out(dmem_tlb_miss_in)
  );
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  function automatic logic [31:0] fi(input logic [5:0] op, input int rs, rt, imm);
    return {op, 5'(rs), 5'(rt), 16'(imm)};
  endfunction
  function automatic logic [31:0] fr(input int rs, rt, rd, input logic [5:0] fn);
    return {OP_SPECIAL, 5'(rs), 5'(rt), 5'(rd), 5'h00, fn};
  endfunction
  function automatic logic [31:0] dm(input logic [31:0] a);
    return risc_memory_model_i.dmem[a[9:2]];
  endfunction
  task automatic emit(input logic [31:0] w);
    risc_memory_model_i.imem[wp[9:2]] = w;
    wp = wp + PC_STEP;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // holds reset while memory is refilled; handlers store the return pc and cause
  task automatic start();
    @(posedge core_clk_in);
    #1 rst_in = 1'b1;
    for (int i = 0; i < 256; i++) begin
      risc_memory_model_i.imem[i] = 32'h0;
      risc_memory_model_i.dmem[i] = 32'hdead_0000;
    end
    for (int h = 0; h < 2; h++) begin
      wp = h * 32'h80;
      emit(fi(OP_SYS, SYS_READ_EPC, 10, 0));
      emit(fi(OP_SW, 0, 10, h ? 'h210 : 'h200));
      emit(fi(OP_SYS, SYS_READ_CAUSE, 11, 0));
      emit(fi(OP_SW, 0, 11, h ? 'h214 : 'h204));
      emit({OP_J, wp[27:2]});
      emit(32'h0);
    end
    wp = RESET_PC;
  endtask
  task automatic go(input int n);
    emit(fi(OP_BEQ, 0, 0, 'hffff));
    emit(32'h0);
    repeat (10) @(posedge core_clk_in);
    #1 rst_in = 1'b0;
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic t_branch();
    logic [4:0]  rr [7] = '{0, 2, 3, 4, 5, 6, 31};
    logic [31:0] want [7] = '{0, 'h22, 1, 'h44, 'h55, 1, 'h124};
    start();
    emit(fi(OP_ORI, 0, 3, 1));
    emit(fi(OP_ORI, 0, 6, 1));
    emit(fi(OP_BEQ, 0, 0, 2));
    emit(fi(OP_ORI, 0, 2, 'h22));
    emit(fi(OP_ORI, 0, 3, 'h33));
    emit(fi(OP_BNE, 0, 0, 4));
    emit(fi(OP_ORI, 0, 4, 'h44));
    emit({OP_JAL, 26'h4a});
    emit(fi(OP_ORI, 0, 5, 'h55));
    emit(fi(OP_ORI, 0, 6, 'h66));
    emit(fi(OP_ADDI, 0, 0, 'h77));
    foreach (rr[i]) emit(fi(OP_SW, 0, rr[i], 'h300 + 4 * i));
    go(60);
    foreach (rr[i]) chk("branch result", want[i], dm('h300 + 4 * i));
  endtask
  task automatic t_load();
    start();
    risc_memory_model_i.dmem[8'hc0] = 32'h5a5a_0003;
    emit(fi(OP_ORI, 0, 1, 1));
    emit(fi(OP_LW, 0, 1, 'h300));
    emit(fr(1, 0, 2, F_OR));
    emit(fr(1, 0, 3, F_OR));
    emit(fi(OP_SW, 0, 2, 'h304));
    emit(fi(OP_SW, 0, 3, 'h308));
    go(40);
    chk("load slot reader", 32'h1, dm('h304));
    chk("later reader", 32'h5a5a_0003, dm('h308));
  endtask
  task automatic t_muldiv();
    logic [4:0]  rr [5] = '{3, 4, 5, 8, 9};
    logic [31:0] want [5] = '{'hffff_ffff, 'hffff_ffee, 5, 3, 1};
    start();
    emit(fi(OP_ORI, 0, 1, 6));
    emit(fi(OP_ADDI, 0, 2, 'hfffd));
    emit(fi(OP_ORI, 0, 5, 5));
    emit(fr(1, 2, 5, F_MULT));
    emit(fr(0, 0, 3, F_MFHI));
    emit(fr(0, 0, 4, F_MFLO));
    emit(fi(OP_ORI, 0, 6, 7));
    emit(fi(OP_ORI, 0, 7, 2));
    emit(fr(6, 7, 5, F_DIV));
    emit(fr(0, 0, 8, F_MFLO));
    emit(fr(0, 0, 9, F_MFHI));
    foreach (rr[i]) emit(fi(OP_SW, 0, rr[i], 'h300 + 4 * i));
    go(80);
    foreach (rr[i]) chk("muldiv result", want[i], dm('h300 + 4 * i));
  endtask
  task automatic t_miss(input logic hi);
    start();
    emit(fi(OP_LUI, 0, 1, hi ? 'hc000 : 'h4000));
    emit(fi(hi ? OP_SW : OP_LW, 1, 2, 0));
    emit(fi(OP_SW, 0, 0, 'h220));
    go(40);
    chk("return pc", RESET_PC + PC_STEP, dm(hi ? 'h210 : 'h200));
    chk("other entry", 32'hdead_0000, dm(hi ? 'h200 : 'h210));
    chk("miss cause", hi ? CAUSE_TLB : CAUSE_USER_TLB, dm(hi ? 'h214 : 'h204));
    chk("flushed store", 32'hdead_0000, dm('h220));
  endtask
  task automatic t_irq();
    start();
    irq_in = 1'b1;
    emit(fi(OP_ORI, 0, 1, 'h99));
    emit(fi(OP_SW, 0, 1, 'h220));
    emit(fi(OP_SYS, SYS_RFE, 0, 0));
    go(60);
    irq_in = 1'b0;
    chk("masked until enabled", 32'h99, dm('h220));
    chk("interrupt return pc", 32'h10c, dm('h210));
    chk("interrupt cause", CAUSE_INT, dm('h214));
  endtask
  // a trap in a delay slot must return to the jump so that the slot runs again
  task automatic t_slot_trap();
    start();
    emit(fi(OP_ORI, 0, 4, 'h120));
    emit(fr(4, 0, 31, F_JALR));
    emit(fr(0, 0, 0, F_SYSCALL));
    go(40);
    chk("slot trap return pc", 32'h104, dm('h210));
    chk("syscall cause", CAUSE_SYSCALL, dm('h214));
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    rst_in = 1'b1;
    irq_in = 1'b0;
    fail_count = 0;
    n_checks = 0;
    wp = '0;
    t_branch();
    t_load();
    t_muldiv();
    t_miss(1'b0);
    t_miss(1'b1);
    t_irq();
    t_slot_trap();
    summarize();
  end
  // seven runs of under 100 cycles each; a hang stops far beyond that
  initial begin
    #(20 * 3000);
    fail_count++;
    summarize();
  end
endmodule
